// File: include/dfc_pkg.sv
// Constants, types and helpers shared by the dynamic fan floor control block
// Operation
// - Every bit of dynamic floor control register 1 reads zero after reset.
// - Bit 0 of that register is the top bit of the three-bit far 2 interval code, the low two sit in register 2.
// - The three-bit interval code sets, in monitoring cycles, the wait between floor adjustments of its channel.
// - Code 000 gives a decrease wait of 8 cycles doubling per step to 1024, the increase wait being twice that.
// - With the core voltage low option set, standby supply and core voltage below its limit, status bit 1 sets.
// - In that same condition processor hot monitoring stops and shutdown entry is blocked.
// - With bit 2 set the far 1 temperature is copied to its operating point when the overtemp pin asserts.
// - With bit 3 set the local temperature is copied to its operating point when the overtemp pin asserts.
// - With bit 4 set the far 2 temperature is copied to its operating point when the overtemp pin asserts.
// - With a capture bit clear the overtemp pin is ignored and that operating point keeps its programmed value.
// - The far 1, local and far 2 operating points sit at 0x8B, 0x8C and 0x8D and reset to 0x64.
// - Bits 5, 6 and 7 enable dynamic floor adjustment on the far 1, local and far 2 channels.
// - With a dynamic enable clear the channel makes no floor adjustments and runs plain automatic control.
// - Once the configuration lock bit is set, writes to these registers are discarded.
package dfc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MON_CYCLE_MS = 125;
  localparam int unsigned MON_CYCLE_CLKS = (CLK_HZ / 1000) * MON_CYCLE_MS;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned CNT_W = 12;

  localparam logic [7:0] IDX_CFG1 = 8'h40;
  localparam logic [7:0] IDX_CORE_LOW = 8'h46;
  localparam logic [7:0] IDX_OP_FAR1 = 8'h8b;
  localparam logic [7:0] IDX_OP_LOCAL = 8'h8c;
  localparam logic [7:0] IDX_OP_FAR2 = 8'h8d;
  localparam logic [7:0] IDX_DYN1 = 8'h8e;
  localparam logic [7:0] IDX_DYN2 = 8'h8f;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;

  localparam logic [7:0] RST_DYN = 8'h00;
  localparam logic [7:0] RST_OP = 8'h64;
  localparam logic [7:0] RST_CORE_LOW = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;

  localparam int unsigned CFG1_LOCK = 0;
  localparam int unsigned DYN1_FAR2_MSB = 0;
  localparam int unsigned DYN1_CORE_LOW = 1;
  localparam int unsigned DYN1_CAP_FAR1 = 2;
  localparam int unsigned DYN1_CAP_LOCAL = 3;
  localparam int unsigned DYN1_CAP_FAR2 = 4;
  localparam int unsigned DYN1_EN_FAR1 = 5;
  localparam int unsigned DYN1_EN_LOCAL = 6;
  localparam int unsigned DYN1_EN_FAR2 = 7;
  localparam int unsigned IRQ_CAPTURE = 0;
  localparam int unsigned IRQ_CORE_LOW = 1;

  localparam logic [CNT_W-1:0] DEC_BASE = 12'h008;

  typedef struct packed {
    logic [7:0] far2;
    logic [7:0] loc;
    logic [7:0] far1;
  } dfc_temps_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RWAIT = 2'b10,
    BUS_RDONE = 2'b11
  } dfc_bus_state_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  function automatic logic [CNT_W-1:0] dec_interval(input logic [2:0] code);
    dec_interval = DEC_BASE << code;
  endfunction

  function automatic logic [CNT_W-1:0] inc_interval(input logic [2:0] code);
    inc_interval = dec_interval(code) << 1;
  endfunction
endpackage

// File: design/dfc_interval.sv
// Per-channel floor adjustment pacing timer
`timescale 1ns/100ps
module dfc_interval
  import dfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic mon_tick_in,
  input wire logic [2:0] code_in,
  output logic dec_step_out,
  output logic inc_step_out
);
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic dec_reg, dec_next, inc_reg, inc_next;
  logic [CNT_W-1:0] cnt_plus;

  always_comb begin
    cnt_plus = cnt_reg + 12'h001;
    cnt_next = cnt_reg;
    dec_next = 1'b0;
    inc_next = 1'b0;
    if (!enable_in) begin
      cnt_next = '0;
    end else if (mon_tick_in) begin
      cnt_next = cnt_plus;
      if (cnt_plus >= inc_interval(code_in)) begin
        cnt_next = '0;
        inc_next = 1'b1;
        dec_next = 1'b1;
      end else if (cnt_plus == dec_interval(code_in)) begin
        dec_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= '0;
      dec_reg <= 1'b0;
      inc_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dec_reg <= dec_next;
      inc_reg <= inc_next;
    end
  end

  assign dec_step_out = dec_reg;
  assign inc_step_out = inc_reg;
endmodule

// File: design/dfc_top.sv
// Dynamic fan floor control registers with AHB-Lite slave
`timescale 1ns/100ps
module dfc_top
  import dfc_pkg::*;
#(
  parameter int unsigned MON_CLKS = MON_CYCLE_CLKS
)(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [23:0] temps_in,
  input wire logic temps_valid_in,
  input wire logic overtemp_pin_n_in,
  input wire logic standby_supply_in,
  input wire logic [7:0] core_voltage_in,
  output logic [23:0] op_points_out,
  output logic [2:0] dynamic_enable_out,
  output logic [2:0] dec_step_out,
  output logic [2:0] inc_step_out,
  output logic processor_hot_monitor_en_out,
  output logic shutdown_block_out,
  output logic irq_out
);
  // Refused at elaboration; a zero count would never tick
  if (MON_CLKS < 2) begin : g_mon_check
    $error("MON_CLKS must be at least 2");
  end

  dfc_bus_state_t bus_reg, bus_next;
  logic [7:0] idx_reg, idx_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] dyn1_reg, dyn1_next, dyn2_reg, dyn2_next, low_reg, low_next;
  dfc_temps_t op_reg, op_next, meas_reg, meas_next;
  logic lock_reg, lock_next;
  logic [1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic ot_d_reg, ot_d_next;
  logic [31:0] mon_cnt_reg, mon_cnt_next;
  logic mon_tick;
  logic addr_ok, ot_rise, core_low, wr_en, wr_open;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [2:0] far2_code;

  // Bus front end: reads take one wait state so a just-written value is seen
  assign addr_ok = hsel_in && hready_in && htrans_in[1];

  always_comb begin
    bus_next = BUS_IDLE;
    idx_next = idx_reg;
    if (addr_ok) begin
      idx_next = haddr_in[9:2];
      bus_next = hwrite_in ? BUS_WRITE : BUS_RWAIT;
    end
    if (bus_reg == BUS_RWAIT) begin
      bus_next = BUS_RDONE;
      idx_next = idx_reg;
    end
  end

  always_comb begin
    case (idx_reg)
      IDX_CFG1: rd_byte = {7'h00, lock_reg};
      IDX_CORE_LOW: rd_byte = low_reg;
      IDX_OP_FAR1: rd_byte = op_reg.far1;
      IDX_OP_LOCAL: rd_byte = op_reg.loc;
      IDX_OP_FAR2: rd_byte = op_reg.far2;
      IDX_DYN1: rd_byte = dyn1_reg;
      IDX_DYN2: rd_byte = dyn2_reg;
      IDX_IRQ_STAT: rd_byte = {6'h00, stat_reg};
      IDX_IRQ_MASK: rd_byte = {6'h00, mask_reg};
      default: rd_byte = 8'h00;
    endcase
    rdata_next = rdata_reg;
    if (bus_reg == BUS_RWAIT) begin
      rdata_next = {24'h000000, rd_byte};
    end
  end

  assign hreadyout_out = (bus_reg != BUS_RWAIT);
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_reg;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_reg <= BUS_IDLE;
      idx_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end else begin
      bus_reg <= bus_next;
      idx_reg <= idx_next;
      rdata_reg <= rdata_next;
    end
  end

  // Monitoring cycle pacing and measurement tracking
  assign mon_tick = (mon_cnt_reg == MON_CLKS - 1);
  assign ot_rise = !overtemp_pin_n_in && ot_d_reg;
  assign core_low = dyn1_reg[DYN1_CORE_LOW] && standby_supply_in && (core_voltage_in < low_reg);

  always_comb begin
    mon_cnt_next = mon_tick ? 32'h00000000 : mon_cnt_reg + 32'h00000001;
    ot_d_next = overtemp_pin_n_in;
    meas_next = meas_reg;
    if (temps_valid_in) begin
      meas_next = dfc_temps_t'(temps_in);
    end
  end

  // Register file; lock only gates the floor control group
  assign wr_en = (bus_reg == BUS_WRITE);
  assign wr_open = wr_en && !lock_reg;
  assign wbyte = hwdata_in[7:0];

  always_comb begin
    dyn1_next = dyn1_reg;
    dyn2_next = dyn2_reg;
    low_next = low_reg;
    op_next = op_reg;
    lock_next = lock_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (wr_open) begin
      case (idx_reg)
        IDX_CORE_LOW: low_next = wbyte;
        IDX_OP_FAR1: op_next.far1 = wbyte;
        IDX_OP_LOCAL: op_next.loc = wbyte;
        IDX_OP_FAR2: op_next.far2 = wbyte;
        IDX_DYN1: dyn1_next = wbyte;
        IDX_DYN2: dyn2_next = wbyte;
        IDX_CFG1: lock_next = wbyte[CFG1_LOCK];
        default: lock_next = lock_reg;
      endcase
    end
    if (wr_en && idx_reg == IDX_IRQ_MASK) begin
      mask_next = wbyte[1:0];
    end
    if (wr_en && idx_reg == IDX_IRQ_STAT) begin
      stat_next = stat_reg & ~wbyte[1:0];
    end
    // Captures and status sets come last so they beat a same-cycle write
    if (ot_rise && dyn1_reg[DYN1_CAP_FAR1]) begin
      op_next.far1 = meas_reg.far1;
    end
    if (ot_rise && dyn1_reg[DYN1_CAP_LOCAL]) begin
      op_next.loc = meas_reg.loc;
    end
    if (ot_rise && dyn1_reg[DYN1_CAP_FAR2]) begin
      op_next.far2 = meas_reg.far2;
    end
    if (ot_rise && |dyn1_reg[DYN1_CAP_FAR2:DYN1_CAP_FAR1]) begin
      stat_next[IRQ_CAPTURE] = 1'b1;
    end
    if (core_low) begin
      stat_next[IRQ_CORE_LOW] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dyn1_reg <= RST_DYN;
      dyn2_reg <= RST_DYN;
      low_reg <= RST_CORE_LOW;
      op_reg <= {RST_OP, RST_OP, RST_OP};
      lock_reg <= 1'b0;
      mask_reg <= RST_IRQ;
      stat_reg <= RST_IRQ;
      meas_reg <= '0;
      ot_d_reg <= 1'b1;
      mon_cnt_reg <= 32'h00000000;
    end else begin
      dyn1_reg <= dyn1_next;
      dyn2_reg <= dyn2_next;
      low_reg <= low_next;
      op_reg <= op_next;
      lock_reg <= lock_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      meas_reg <= meas_next;
      ot_d_reg <= ot_d_next;
      mon_cnt_reg <= mon_cnt_next;
    end
  end

  // Outputs; the alert is the masked status, so it is enabled by a mask bit
  assign irq_out = |(stat_reg & mask_reg);
  assign processor_hot_monitor_en_out = !core_low;
  assign shutdown_block_out = core_low;
  assign op_points_out = op_reg;
  assign dynamic_enable_out = dyn1_reg[DYN1_EN_FAR2:DYN1_EN_FAR1];
  assign far2_code = {dyn1_reg[DYN1_FAR2_MSB], dyn2_reg[7:6]};

  dfc_interval u_far1 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(dyn1_reg[DYN1_EN_FAR1]),
    .mon_tick_in(mon_tick),
    .code_in(dyn2_reg[2:0]),
    .dec_step_out(dec_step_out[0]),
    .inc_step_out(inc_step_out[0])
  );
  dfc_interval u_local (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(dyn1_reg[DYN1_EN_LOCAL]),
    .mon_tick_in(mon_tick),
    .code_in(dyn2_reg[5:3]),
    .dec_step_out(dec_step_out[1]),
    .inc_step_out(inc_step_out[1])
  );
  dfc_interval u_far2 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(dyn1_reg[DYN1_EN_FAR2]),
    .mon_tick_in(mon_tick),
    .code_in(far2_code),
    .dec_step_out(dec_step_out[2]),
    .inc_step_out(inc_step_out[2])
  );

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_locked_write;
    wr_en && lock_reg;
  endsequence
  sequence s_capture_far1;
    ot_rise && dyn1_reg[DYN1_CAP_FAR1];
  endsequence

  property p_reset_dyn1;
    disable iff (1'b0) sys_rst_in |=> (dyn1_reg == RST_DYN && op_reg.loc == RST_OP);
  endproperty
  a_reset_dyn1: assert property (p_reset_dyn1) else $error("Reset values wrong");

  property p_far2_code;
    far2_code[2] == dyn1_reg[DYN1_FAR2_MSB] && far2_code[1:0] == dyn2_reg[7:6];
  endproperty
  a_far2_code: assert property (p_far2_code) else $error("Far 2 code assembled wrong");

  property p_core_low_status;
    core_low |=> stat_reg[IRQ_CORE_LOW];
  endproperty
  a_core_low_status: assert property (p_core_low_status) else $error("Core low status not set");

  property p_core_low_side;
    core_low |-> (shutdown_block_out && !processor_hot_monitor_en_out);
  endproperty
  a_core_low_side: assert property (p_core_low_side) else $error("Core low effects missing");

  property p_capture_far1;
    s_capture_far1 |=> op_reg.far1 == $past(meas_reg.far1);
  endproperty
  a_capture_far1: assert property (p_capture_far1) else $error("Far 1 capture missed");

  property p_no_capture_local;
    (!wr_en && !dyn1_reg[DYN1_CAP_LOCAL]) |=> $stable(op_reg.loc);
  endproperty
  a_no_capture_local: assert property (p_no_capture_local) else $error("Local point changed");

  property p_locked;
    (s_locked_write and (idx_reg == IDX_DYN1 && !ot_rise)) |=> $stable(dyn1_reg);
  endproperty
  a_locked: assert property (p_locked) else $error("Write passed lock");

  property p_one_capture;
    (ot_rise ##1 (!wr_en && !overtemp_pin_n_in)) |=> $stable(op_reg);
  endproperty
  a_one_capture: assert property (p_one_capture) else $error("Capture repeated");

  property p_disabled_quiet;
    !dyn1_reg[DYN1_EN_FAR1] [*2] |-> !dec_step_out[0];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("Step while disabled");

  property p_read_wait;
    (addr_ok && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("Read wait state wrong");
endmodule

// File: tb/dfc_top_tb_top.sv
// Self-checking bench for the dynamic fan floor control registers
`timescale 1ns/100ps
module dfc_top_tb_top;
  import dfc_pkg::*;
  localparam int unsigned MON = 4;
  logic clk_in, sys_rst_in, hsel, hwrite, hready, hresp, tvalid, pin_n, standby, irq, phot_en, sd_block;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, dyn_en, dec_step, inc_step;
  logic [23:0] temps, op_points;
  logic [7:0] core_v;
  int errors, checked, n, stray;

  dfc_top #(.MON_CLKS(MON)) dfc_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .temps_in(temps),
    .temps_valid_in(tvalid), .overtemp_pin_n_in(pin_n), .standby_supply_in(standby), .core_voltage_in(core_v),
    .op_points_out(op_points), .dynamic_enable_out(dyn_en), .dec_step_out(dec_step), .inc_step_out(inc_step),
    .processor_hot_monitor_en_out(phot_en), .shutdown_block_out(sd_block), .irq_out(irq));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic complete_run;
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded waits only; a hung slave ends the run
  task automatic give_up;
    errors++;
    complete_run();
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) give_up();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) give_up();
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk(x, {24'h000000, e});
  endtask

  // Counts edges until the chosen step pulse is seen
  task automatic wait_step(input int ch, input logic inc, output int k);
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while ((inc ? inc_step[ch] : dec_step[ch]) !== 1'b1 && k < 20000);
    if (k >= 20000) give_up();
  endtask

  task automatic load_temps(input logic [23:0] t);
    @(posedge clk_in);
    temps <= t;
    tvalid <= 1'b1;
    @(posedge clk_in);
    tvalid <= 1'b0;
  endtask

  task automatic pin(input logic v);
    @(posedge clk_in);
    pin_n <= v;
    repeat (3) @(posedge clk_in);
  endtask

  initial begin
    sys_rst_in = 1'b1;
    {hsel, hwrite, tvalid, standby} = 4'h0;
    pin_n = 1'b1;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'h2;
    temps = 24'h000000;
    core_v = 8'hff;
    errors = 0;
    checked = 0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rc(IDX_DYN1, 8'h00);
    rc(IDX_OP_FAR1, 8'h64);
    rc(IDX_OP_LOCAL, 8'h64);
    rc(IDX_OP_FAR2, 8'h64);
    chk({8'h00, op_points}, 32'h00646464);
    wr(8'h20, 8'h5a);
    rc(8'h20, 8'h00);
    chk({31'h0, hresp}, 32'h0);
    wr(IDX_DYN1, 8'ha5);
    rc(IDX_DYN1, 8'ha5);
    wr(IDX_DYN1, 8'h5a);
    rc(IDX_DYN1, 8'h5a);
    wr(IDX_DYN1, 8'he0);
    @(posedge clk_in);
    chk({29'h0, dyn_en}, 32'h7);
    wr(IDX_DYN1, 8'h00);
    // Pacing, every far 1 code; re-enable so each code starts from a cleared count
    for (int c = 0; c < 8; c++) begin
      wr(IDX_DYN2, 8'(c));
      wr(IDX_DYN1, 8'h20);
      wait_step(0, 1'b1, n);
      wait_step(0, 1'b0, n);
      chk(n, (8 << c) * MON);
      wait_step(0, 1'b1, n);
      chk(n, (8 << c) * MON);
      wait_step(0, 1'b1, n);
      chk(n, (16 << c) * MON);
      wr(IDX_DYN1, 8'h00);
    end
    // Far 2 code 5 needs the top bit from register 1
    wr(IDX_DYN2, 8'h40);
    wr(IDX_DYN1, 8'h81);
    wait_step(2, 1'b1, n);
    wait_step(2, 1'b0, n);
    chk(n, 256 * MON);
    // Local channel, code 1 in the middle field
    wr(IDX_DYN2, 8'h08);
    wr(IDX_DYN1, 8'h40);
    wait_step(1, 1'b1, n);
    wait_step(1, 1'b0, n);
    chk(n, 16 * MON);
    wr(IDX_DYN1, 8'h00);
    stray = 0;
    repeat (600) begin
      @(posedge clk_in);
      if ((dec_step | inc_step) !== 3'b000) stray++;
    end
    chk(stray, 0);
    // Capture on far 1 only, then on far 1, local and far 2 together
    wr(IDX_IRQ_MASK, 8'h03);
    load_temps(24'h2a1b0c);
    wr(IDX_DYN1, 8'h04);
    pin(1'b0);
    chk({8'h00, op_points}, 32'h0064640c);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_OP_FAR1, 8'h50);
    repeat (4) @(posedge clk_in);
    rc(IDX_OP_FAR1, 8'h50);
    wr(IDX_IRQ_STAT, 8'h01);
    @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    pin(1'b1);
    wr(IDX_DYN1, 8'h1c);
    load_temps(24'h3d2e1f);
    pin(1'b0);
    rc(IDX_OP_FAR1, 8'h1f);
    rc(IDX_OP_LOCAL, 8'h2e);
    rc(IDX_OP_FAR2, 8'h3d);
    rc(IDX_IRQ_STAT, 8'h01);
    pin(1'b1);
    wr(IDX_IRQ_STAT, 8'hff);
    // Core low: equal to the limit is not low
    wr(IDX_IRQ_MASK, 8'h02);
    wr(IDX_CORE_LOW, 8'h80);
    @(posedge clk_in);
    core_v <= 8'h80;
    standby <= 1'b1;
    wr(IDX_DYN1, 8'h02);
    chk({30'h0, phot_en, sd_block}, 32'h2);
    @(posedge clk_in);
    core_v <= 8'h7f;
    repeat (3) @(posedge clk_in);
    chk({30'h0, phot_en, sd_block}, 32'h1);
    rc(IDX_IRQ_STAT, 8'h02);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_MASK, 8'h00);
    @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_in);
    standby <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({30'h0, phot_en, sd_block}, 32'h2);
    // Lock is write-once, so it comes last
    wr(IDX_CFG1, 8'h01);
    wr(IDX_DYN1, 8'he0);
    rc(IDX_DYN1, 8'h02);
    wr(IDX_OP_LOCAL, 8'h11);
    rc(IDX_OP_LOCAL, 8'h2e);
    wr(IDX_IRQ_MASK, 8'h01);
    rc(IDX_IRQ_MASK, 8'h01);
    complete_run();
  end
endmodule
